// File: verilog/changeover_status_indicators.sv
// Status indicators, open-drain alarms, bypass reporting and hot-swap restore
//
// Contract
// - The module fault output sinks to ground while health is green with the main board present, and floats on a severe error, power loss or absent board.
// - Each info alarm output sinks while its indicator is green or orange and floats while it is red.
// - The health indicator is red while faulty or initialising, green when module and power are good, and the fault output follows it.
// - The main-input indicator is red when all four main inputs lose lock and signal, orange for any other loss of lock or signal, green otherwise.
// - The backup-input indicator is red when all four backup inputs lose lock and signal, orange for any other loss of lock or signal, green otherwise.
// - A bypassed reclocker with a recognisable rate reports locked with its rate, otherwise it reports bypass and no rate.
// - A replacement with the same change-over function adopts the configuration, a differing one needs manual configuration.
`timescale 1ns/1ps
`default_nettype none

module changeover_status_indicators #(
  parameter int NS = status_pkg::NUM_STREAMS,
  parameter int NR = status_pkg::NUM_RECLOCKERS,
  parameter int RW = status_pkg::RATE_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Per-stream input alarms
  input wire logic [NS-1:0] main_lol_i,
  input wire logic [NS-1:0] main_los_i,
  input wire logic [NS-1:0] backup_lol_i,
  input wire logic [NS-1:0] backup_los_i,
  // Change-over state
  input wire logic [NS-1:0] backup_sel_i,
  input wire logic [NS-1:0] auto_mode_i,
  // Module health
  input wire logic board_present_i,
  input wire logic severe_error_i,
  input wire logic power_good_i,
  input wire logic init_done_i,
  // Reclocker status
  input wire logic [NR-1:0] rc_bypass_i,
  input wire logic [NR-1:0] rc_lol_i,
  input wire logic [NR-1:0] rate_valid_i,
  input wire logic [NR*RW-1:0] rate_i,
  // Hot-swap configuration restore
  input wire logic cfg_restore_i,
  input wire logic quad_mode_i,
  input wire logic saved_quad_mode_i,
  input wire logic cfg_manual_done_i,
  // Indicator colours
  output status_pkg::colour_t status_colour_o,
  output status_pkg::colour_t info_colour_o [status_pkg::NUM_INFO],
  // Open-drain alarms, low enable means sinking to ground
  output logic [status_pkg::NUM_INFO-1:0] info_alarm_o,
  output logic [status_pkg::NUM_INFO-1:0] info_alarm_oe_n_o,
  output logic fault_alarm_o,
  output logic fault_alarm_oe_n_o,
  // Reclocker reports
  output logic [NR-1:0] report_locked_o,
  output logic [NR-1:0] report_bypass_o,
  output logic [NR*RW-1:0] report_rate_o,
  // Hot-swap outcome
  output logic cfg_adopt_o,
  output logic cfg_manual_o
);

  localparam int CW = status_pkg::INIT_CNT_W;
  localparam logic [CW-1:0] INIT_LOAD = CW'(status_pkg::INIT_CYCLES - 1);

  status_pkg::health_t state_r, state_nxt;
  logic [CW-1:0] init_cnt_r;
  status_pkg::colour_t status_colour_r;
  status_pkg::colour_t info_colour_r [status_pkg::NUM_INFO];
  status_pkg::colour_t info_colour_w [status_pkg::NUM_INFO];
  logic [status_pkg::NUM_INFO-1:0] info_oe_n_r;
  logic fault_oe_n_r;
  logic [NR-1:0] locked_r, bypass_r;
  logic [NR*RW-1:0] rate_r;
  logic adopt_r, manual_r;

  // Health decision terms
  wire module_good = power_good_i & ~severe_error_i;
  wire init_over = (init_cnt_r == '0) & init_done_i;

  // Health state machine, red until the init window and module report ready
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      status_pkg::ST_INIT: begin
        if (init_over && module_good) begin
          state_nxt = status_pkg::ST_OK;
        end
      end
      status_pkg::ST_OK: begin
        if (!module_good) begin
          state_nxt = status_pkg::ST_FAULT;
        end
      end
      status_pkg::ST_FAULT: begin
        if (module_good) begin
          state_nxt = status_pkg::ST_OK;
        end
      end
      default: begin
        state_nxt = status_pkg::ST_INIT;
      end
    endcase
  end

  // Health state and initialisation timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= status_pkg::ST_INIT;
      init_cnt_r <= INIT_LOAD;
    end else begin
      state_r <= state_nxt;
      if (init_cnt_r != '0) begin
        init_cnt_r <= init_cnt_r - CW'(1);
      end
    end
  end

  // Info indicators: main inputs, backup inputs, backup selection among auto streams
  info_colour #(.N(NS)) u_info_main (
    .lol_i(main_lol_i),
    .los_i(main_los_i),
    .consider_i({NS{1'b1}}),
    .colour_o(info_colour_w[status_pkg::INFO_MAIN])
  );
  info_colour #(.N(NS)) u_info_backup (
    .lol_i(backup_lol_i),
    .los_i(backup_los_i),
    .consider_i({NS{1'b1}}),
    .colour_o(info_colour_w[status_pkg::INFO_BACKUP])
  );
  info_colour #(.N(NS)) u_info_select (
    .lol_i(backup_sel_i),
    .los_i(backup_sel_i),
    .consider_i(auto_mode_i),
    .colour_o(info_colour_w[status_pkg::INFO_SELECT])
  );

  // Indicator registers and open-drain enables derived from them
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_colour_r <= status_pkg::COL_RED;
      info_colour_r <= '{default: status_pkg::COL_OFF};
      info_oe_n_r <= {status_pkg::NUM_INFO{status_pkg::RST_OE_N}};
      fault_oe_n_r <= status_pkg::RST_OE_N;
    end else begin
      status_colour_r <= (state_r == status_pkg::ST_OK) ? status_pkg::COL_GREEN : status_pkg::COL_RED;
      info_colour_r <= info_colour_w;
      for (int i = 0; i < status_pkg::NUM_INFO; i++) begin
        info_oe_n_r[i] <= (info_colour_r[i] == status_pkg::COL_RED);
      end
      fault_oe_n_r <= (status_colour_r != status_pkg::COL_GREEN) || !board_present_i;
    end
  end

  // Reclocker reports, bypassed channels show lock only with a recognised rate
  generate
    for (genvar c = 0; c < NR; c++) begin : g_rc
      wire show_lock = rc_bypass_i[c] ? rate_valid_i[c] : ~rc_lol_i[c];
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          locked_r[c] <= 1'b0;
          bypass_r[c] <= 1'b0;
          rate_r[c*RW +: RW] <= status_pkg::RATE_NONE;
        end else begin
          locked_r[c] <= show_lock;
          bypass_r[c] <= rc_bypass_i[c] & ~rate_valid_i[c];
          rate_r[c*RW +: RW] <= show_lock ? rate_i[c*RW +: RW] : status_pkg::RATE_NONE;
        end
      end
      chk_bypass_lock: assert property (@(posedge clk_i) disable iff (rst_i)
        rc_bypass_i[c] && rate_valid_i[c] |=> report_locked_o[c] && !report_bypass_o[c]
          && report_rate_o[c*RW +: RW] == $past(rate_i[c*RW +: RW]))
        else $error("Bypassed channel with rate not reported locked");
      chk_bypass_norate: assert property (@(posedge clk_i) disable iff (rst_i)
        rc_bypass_i[c] && !rate_valid_i[c] |=> report_bypass_o[c] && !report_locked_o[c]
          && report_rate_o[c*RW +: RW] == status_pkg::RATE_NONE)
        else $error("Bypassed channel without rate not reported as bypass");
    end
  endgenerate

  // Hot-swap: matching function adopts, a mismatch waits for manual setup
  wire func_match = (quad_mode_i == saved_quad_mode_i);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      adopt_r <= 1'b0;
      manual_r <= 1'b0;
    end else begin
      adopt_r <= cfg_restore_i & func_match;
      if (cfg_restore_i && !func_match) begin
        manual_r <= 1'b1;
      end else if (cfg_manual_done_i) begin
        manual_r <= 1'b0;
      end
    end
  end

  // Output drive, open-drain data is always low
  assign status_colour_o = status_colour_r;
  assign info_colour_o = info_colour_r;
  assign info_alarm_o = '0;
  assign info_alarm_oe_n_o = info_oe_n_r;
  assign fault_alarm_o = 1'b0;
  assign fault_alarm_oe_n_o = fault_oe_n_r;
  assign report_locked_o = locked_r;
  assign report_bypass_o = bypass_r;
  assign report_rate_o = rate_r;
  assign cfg_adopt_o = adopt_r;
  assign cfg_manual_o = manual_r;

  // Health comes up, turns green, then the fault output sinks unless the board has gone meanwhile
  sequence s_ready;
    state_r == status_pkg::ST_INIT && init_over && module_good;
  endsequence
  sequence s_green_then_sink;
    state_r == status_pkg::ST_OK ##1 status_colour_r == status_pkg::COL_GREEN
      ##1 fault_oe_n_r == $past(!board_present_i);
  endsequence

  chk_health_up: assert property (@(posedge clk_i) disable iff (rst_i)
    s_ready ##0 (board_present_i && module_good)[*3] |=> s_green_then_sink)
    else $error("Health did not reach green with sinking fault output");
  chk_init_red: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r == status_pkg::ST_INIT |=> status_colour_r == status_pkg::COL_RED ##1 fault_oe_n_r)
    else $error("Status not red while initialising");
  chk_fault_float: assert property (@(posedge clk_i) disable iff (rst_i)
    severe_error_i ##1 1'b1 |=> ##1 fault_oe_n_r)
    else $error("Fault output not floating on severe error");
  chk_board_absent: assert property (@(posedge clk_i) disable iff (rst_i)
    !board_present_i |=> fault_oe_n_r)
    else $error("Fault output not floating without main board");
  chk_info_float: assert property (@(posedge clk_i) disable iff (rst_i)
    (&(main_lol_i & main_los_i)) |=> ##1 info_alarm_oe_n_o[status_pkg::INFO_MAIN])
    else $error("Main info alarm not floating on red");
  chk_info_sink: assert property (@(posedge clk_i) disable iff (rst_i)
    info_colour_r[status_pkg::INFO_BACKUP] inside {status_pkg::COL_GREEN, status_pkg::COL_ORANGE}
      |=> !info_alarm_oe_n_o[status_pkg::INFO_BACKUP])
    else $error("Backup info alarm not sinking on green or orange");
  chk_main_green: assert property (@(posedge clk_i) disable iff (rst_i)
    !(|(main_lol_i | main_los_i)) |=> info_colour_o[status_pkg::INFO_MAIN] == status_pkg::COL_GREEN)
    else $error("Main indicator not green with all inputs good");
  chk_backup_orange: assert property (@(posedge clk_i) disable iff (rst_i)
    |(backup_lol_i | backup_los_i) && !(&(backup_lol_i & backup_los_i))
      |=> info_colour_o[status_pkg::INFO_BACKUP] == status_pkg::COL_ORANGE)
    else $error("Backup indicator not orange with partial loss");
  chk_cfg_adopt: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_restore_i && func_match |=> cfg_adopt_o && !$rose(cfg_manual_o))
    else $error("Matching replacement did not adopt configuration");
  chk_cfg_manual: assert property (@(posedge clk_i) disable iff (rst_i)
    cfg_restore_i && !func_match |=> cfg_manual_o && !cfg_adopt_o)
    else $error("Mismatched replacement did not request manual setup");

endmodule : changeover_status_indicators
`default_nettype wire

// File: verilog/status_pkg.sv
// Shared constants and types for the change-over status indicator block
`default_nettype none
package status_pkg;

  // Number of change-over streams and reclocker channels
  localparam int NUM_STREAMS = 4;
  localparam int NUM_RECLOCKERS = 8;
  localparam int RATE_W = 4;

  // Clock and initialisation timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int INIT_TIME_NS = 10000;
  localparam int INIT_CYCLES = (INIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INIT_CNT_W = $clog2(INIT_CYCLES + 1);

  // Index of each info indicator
  localparam int INFO_MAIN = 0;
  localparam int INFO_BACKUP = 1;
  localparam int INFO_SELECT = 2;
  localparam int NUM_INFO = 3;

  // Reset values
  localparam logic RST_OE_N = 1'b1;
  localparam logic [RATE_W-1:0] RATE_NONE = 4'h0;

  // Indicator colour codes
  typedef enum logic [1:0] {
    COL_OFF = 2'h0,
    COL_GREEN = 2'h1,
    COL_ORANGE = 2'h2,
    COL_RED = 2'h3
  } colour_t;

  // Module health states
  typedef enum logic [2:0] {
    ST_INIT = 3'h1,
    ST_OK = 3'h2,
    ST_FAULT = 3'h4
  } health_t;

endpackage : status_pkg
`default_nettype wire

// File: verilog/info_colour.sv
// Tri-colour aggregation of per-stream alarm pairs
`timescale 1ns/1ps
`default_nettype none

module info_colour #(
  parameter int N = 4
) (
  // Per-stream alarms and the streams taken into account
  input wire logic [N-1:0] lol_i,
  input wire logic [N-1:0] los_i,
  input wire logic [N-1:0] consider_i,
  // Resulting colour
  output status_pkg::colour_t colour_o
);

  // All considered streams have both alarms, any has one, or none
  wire all_bad = &((lol_i & los_i) | ~consider_i);
  wire any_bad = |((lol_i | los_i) & consider_i);
  wire none_considered = ~|consider_i;

  // Red beats orange beats green; nothing considered leaves it dark
  assign colour_o = none_considered ? status_pkg::COL_OFF :
                    all_bad ? status_pkg::COL_RED :
                    any_bad ? status_pkg::COL_ORANGE : status_pkg::COL_GREEN;

endmodule : info_colour
`default_nettype wire

// File: dv/alarm_pullups.sv
// Pull-up model of the open-drain alarm wires read by an external alarm system
`timescale 1ns/1ps
`default_nettype none

module alarm_pullups (
  // Open-drain drive from the block
  input wire logic [2:0] info_alarm_i,
  input wire logic [2:0] info_oe_n_i,
  input wire logic fault_alarm_i,
  input wire logic fault_oe_n_i,
  // Wire levels seen by the alarm system
  output logic [2:0] info_level_o,
  output logic fault_level_o
);
  // A released wire goes to the pull-up level, a driven one carries the data
  assign info_level_o = info_oe_n_i | info_alarm_i;
  assign fault_level_o = fault_oe_n_i | fault_alarm_i;
endmodule : alarm_pullups
`default_nettype wire

// File: dv/tb_changeover_status_indicators.sv
// Self-checking bench for the status indicator block
`timescale 1ns/1ps
`default_nettype none

module tb_changeover_status_indicators;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] main_lol_i = '0, main_los_i = '0, backup_lol_i = '0, backup_los_i = '0;
  logic [3:0] backup_sel_i = '0, auto_mode_i = '0;
  logic board_present_i = 1'b1, severe_error_i = 1'b0, power_good_i = 1'b1, init_done_i = 1'b1;
  logic [7:0] rc_bypass_i = '0, rc_lol_i = '0, rate_valid_i = '0;
  logic [31:0] rate_i = '0, seed = 32'h4fbd1be2, r;
  logic cfg_restore_i = 1'b0, quad_mode_i = 1'b0, saved_quad_mode_i = 1'b0, cfg_manual_done_i = 1'b0;
  status_pkg::colour_t status_col, exp_col [3];
  status_pkg::colour_t info_col [status_pkg::NUM_INFO];
  logic [2:0] info_alarm, info_oe_n, info_lvl;
  logic fault_alarm, fault_oe_n, fault_lvl, adopt, manual;
  logic [7:0] rep_locked, rep_bypass;
  logic [31:0] rep_rate;
  int num_errors = 0, checked = 0, n;

  // Clock of 4 ns
  always #2 clk_i = ~clk_i;

  changeover_status_indicators u_changeover_status_indicators (.clk_i(clk_i), .rst_i(rst_i),
    .main_lol_i(main_lol_i), .main_los_i(main_los_i), .backup_lol_i(backup_lol_i),
    .backup_los_i(backup_los_i), .backup_sel_i(backup_sel_i), .auto_mode_i(auto_mode_i),
    .board_present_i(board_present_i), .severe_error_i(severe_error_i), .power_good_i(power_good_i),
    .init_done_i(init_done_i), .rc_bypass_i(rc_bypass_i), .rc_lol_i(rc_lol_i), .rate_valid_i(rate_valid_i),
    .rate_i(rate_i), .cfg_restore_i(cfg_restore_i), .quad_mode_i(quad_mode_i),
    .saved_quad_mode_i(saved_quad_mode_i), .cfg_manual_done_i(cfg_manual_done_i),
    .status_colour_o(status_col), .info_colour_o(info_col), .info_alarm_o(info_alarm),
    .info_alarm_oe_n_o(info_oe_n), .fault_alarm_o(fault_alarm), .fault_alarm_oe_n_o(fault_oe_n),
    .report_locked_o(rep_locked), .report_bypass_o(rep_bypass), .report_rate_o(rep_rate),
    .cfg_adopt_o(adopt), .cfg_manual_o(manual));

  alarm_pullups u_alarm_pullups (.info_alarm_i(info_alarm), .info_oe_n_i(info_oe_n),
    .fault_alarm_i(fault_alarm), .fault_oe_n_i(fault_oe_n), .info_level_o(info_lvl),
    .fault_level_o(fault_lvl));

  // Random source
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction : rnd

  // Colour of a group of lock and signal alarms
  function automatic status_pkg::colour_t pair_col(input logic [3:0] lol, input logic [3:0] los);
    if ((lol & los) == 4'hf) return status_pkg::COL_RED;
    if ((lol | los) != 4'h0) return status_pkg::COL_ORANGE;
    return status_pkg::COL_GREEN;
  endfunction : pair_col

  // Colour of the backup selection indicator
  function automatic status_pkg::colour_t sel_col(input logic [3:0] a, input logic [3:0] s);
    if (a == 4'h0) return status_pkg::COL_OFF;
    if ((a & s) == a) return status_pkg::COL_RED;
    if ((a & s) == 4'h0) return status_pkg::COL_GREEN;
    return status_pkg::COL_ORANGE;
  endfunction : sel_col

  // Expected reclocker reports as locked, bypass, rate
  function automatic logic [47:0] rc_exp();
    logic [47:0] e;
    e = '0;
    for (int c = 0; c < 8; c++) begin
      e[40+c] = rc_bypass_i[c] ? rate_valid_i[c] : !rc_lol_i[c];
      e[32+c] = rc_bypass_i[c] & !rate_valid_i[c];
      if (e[40+c]) e[4*c+:4] = rate_i[4*c+:4];
    end
    return e;
  endfunction : rc_exp

  // Compare and count
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick();
    @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wrap_up();
    if (num_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    repeat (6) tick();
    rst_i = 1'b0;
    chk(status_col, status_pkg::COL_RED);
    chk(fault_lvl, 1'b1);
    n = 0;
    while (status_col !== status_pkg::COL_GREEN && n < 3000) begin
      tick();
      n++;
    end
    if (n >= 3000) begin
      num_errors++;
    end
    chk(n >= 2500, 1'b1);
    repeat (2) tick();
    chk(fault_lvl, 1'b0);
    // Severe error, power loss, absent board
    for (int f = 0; f < 3; f++) begin
      severe_error_i = (f == 0);
      power_good_i = (f != 1);
      board_present_i = (f != 2);
      repeat (4) tick();
      chk(fault_lvl, 1'b1);
      if (f < 2) chk(status_col, status_pkg::COL_RED);
      severe_error_i = 1'b0;
      power_good_i = 1'b1;
      board_present_i = 1'b1;
      repeat (4) tick();
      chk({status_col, fault_lvl}, {status_pkg::COL_GREEN, 1'b0});
    end
    // Random alarms with all-clear and all-lost corners
    for (int i = 0; i < 60; i++) begin
      r = rnd();
      {main_lol_i, main_los_i, backup_lol_i, backup_los_i, backup_sel_i, auto_mode_i} = r[23:0];
      if (i < 4) {main_lol_i, main_los_i, backup_lol_i, backup_los_i, auto_mode_i} = {20{i[0]}};
      else {main_lol_i[0], main_los_i[0], backup_lol_i[0], backup_los_i[0]} = 4'h0;
      r = rnd();
      {rc_bypass_i, rc_lol_i, rate_valid_i} = r[23:0];
      rate_i = rnd();
      repeat (3) tick();
      exp_col[0] = pair_col(main_lol_i, main_los_i);
      exp_col[1] = pair_col(backup_lol_i, backup_los_i);
      exp_col[2] = sel_col(auto_mode_i, backup_sel_i);
      chk(info_col[0], exp_col[0]);
      chk(info_col[1], exp_col[1]);
      chk(info_col[2], exp_col[2]);
      for (int k = 0; k < 3; k++) begin
        if (exp_col[k] != status_pkg::COL_OFF) chk(info_lvl[k], exp_col[k] == status_pkg::COL_RED);
      end
      chk({rep_locked, rep_bypass, rep_rate}, rc_exp());
    end
    // Hot swap, matching then differing function
    for (int m = 0; m < 2; m++) begin
      quad_mode_i = m[0];
      saved_quad_mode_i = 1'b0;
      cfg_restore_i = 1'b1;
      tick();
      cfg_restore_i = 1'b0;
      chk({adopt, manual}, {m == 0, m == 1});
      tick();
      chk({adopt, manual}, {1'b0, m == 1});
    end
    cfg_manual_done_i = 1'b1;
    tick();
    cfg_manual_done_i = 1'b0;
    chk(manual, 1'b0);
    // Reset in mid-run with initialisation not done: stays red past the init window
    rst_i = 1'b1;
    init_done_i = 1'b0;
    repeat (2) tick();
    rst_i = 1'b0;
    chk({status_col, fault_lvl}, {status_pkg::COL_RED, 1'b1});
    repeat (2600) tick();
    chk({status_col, fault_lvl}, {status_pkg::COL_RED, 1'b1});
    init_done_i = 1'b1;
    repeat (3) tick();
    chk({status_col, fault_lvl}, {status_pkg::COL_GREEN, 1'b0});
    wrap_up();
  end
endmodule : tb_changeover_status_indicators
`default_nettype wire
